/* design/asbw_ctrl.sv */
// Controller that runs read and write cycles on a bit-wide asynchronous SRAM.
`timescale 1ns/10ps
module asbw_ctrl
   import asbw_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire asbw_req_t  req,
   output logic            req_ready,
   output logic            rd_valid,
   output logic            rd_data,
   output asbw_pins_t      mem_pins,
   input  wire logic       mem_dout
);
   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic [1:0] rst_pipe_r;
   logic       rst_sync_b;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe_r <= 2'h0;
      end else begin
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_pipe_r[1];

   // ****************************************************************
   // Data output synchroniser
   // ****************************************************************
   logic dout_sync;

   asbw_sync3 u_dout_sync (
      .clk_sys    (clk_sys),
      .rst_sync_b (rst_sync_b),
      .async_in   (mem_dout),
      .sync_out   (dout_sync)
   );

   // ****************************************************************
   // Cycle sequencer
   // ****************************************************************
   typedef struct packed {
      asbw_state_t      st;
      logic [CNT_W-1:0] cnt;
      asbw_pins_t       pins;
      logic             rd_valid;
      logic             rd_data;
   } asbw_regs_t;

   asbw_regs_t st_r;
   asbw_regs_t st_nxt;

   assign req_ready = (st_r.st == ASBW_IDLE);
   assign mem_pins  = st_r.pins;
   assign rd_valid  = st_r.rd_valid;
   assign rd_data   = st_r.rd_data;

   always_comb begin
      st_nxt          = st_r;
      st_nxt.rd_valid = 1'b0;
      unique case (st_r.st)
         ASBW_IDLE: begin
            // Address moves only here, with select and strobe both high.
            if (req.valid) begin
               st_nxt.pins.addr = req.addr;
               st_nxt.pins.din  = req.wdata;
               st_nxt.cnt       = '0;
               // Address is set a cycle ahead of any strobe edge.
               st_nxt.st = req.write ? ASBW_WSETUP : ASBW_RSEL;
            end
         end
         ASBW_RSEL: begin
            // Select and output enable fall after the address has settled.
            st_nxt.pins.select_n = 1'b0;
            st_nxt.pins.out_en_n = 1'b0;
            st_nxt.st            = ASBW_RWAIT;
         end
         ASBW_RWAIT: begin
            // Host never drives the data output line, so no opposing drive arises.
            if (st_r.cnt == CNT_W'(READ_WAIT_CYC - 1)) begin
               st_nxt.rd_data       = dout_sync;
               st_nxt.rd_valid      = 1'b1;
               st_nxt.pins.select_n = 1'b1;
               st_nxt.pins.out_en_n = 1'b1;
               st_nxt.cnt           = '0;
               st_nxt.st            = ASBW_TURN;
            end else begin
               st_nxt.cnt = st_r.cnt + 1'b1;
            end
         end
         ASBW_WSETUP: begin
            // Select and strobe fall together so the output stays floating.
            st_nxt.pins.select_n  = 1'b0;
            st_nxt.pins.wstrobe_n = 1'b0;
            st_nxt.st             = ASBW_WPULSE;
         end
         ASBW_WPULSE: begin
            // Pulse covers write width, address, select and data setup.
            if (st_r.cnt == CNT_W'(WRITE_PULSE_CYC - 1)) begin
               st_nxt.pins.select_n  = 1'b1;
               st_nxt.pins.wstrobe_n = 1'b1;
               st_nxt.cnt            = '0;
               st_nxt.st             = ASBW_TURN;
            end else begin
               st_nxt.cnt = st_r.cnt + 1'b1;
            end
         end
         ASBW_TURN: begin
            // Address and data hold past the write end before the next request.
            if (st_r.cnt == CNT_W'(TURN_CYC - 1)) begin
               st_nxt.st = ASBW_IDLE;
            end else begin
               st_nxt.cnt = st_r.cnt + 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st_r.st             <= ASBW_IDLE;
         st_r.cnt            <= '0;
         st_r.pins.select_n  <= 1'b1;
         st_r.pins.out_en_n  <= 1'b1;
         st_r.pins.wstrobe_n <= 1'b1;
         st_r.pins.addr      <= '0;
         st_r.pins.din       <= 1'b0;
         st_r.rd_valid       <= 1'b0;
         st_r.rd_data        <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule

/* design/asbw_sync3.sv */
// Three-stage input synchroniser that reports a level once stages two and three agree.
`timescale 1ns/10ps
module asbw_sync3 (
   input  wire logic clk_sys,
   input  wire logic rst_sync_b,
   input  wire logic async_in,
   output logic      sync_out
);
   logic [2:0] stage_r;

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         stage_r  <= 3'h0;
         sync_out <= 1'b0;
      end else begin
         stage_r <= {stage_r[1:0], async_in};
         if (stage_r[1] == stage_r[2]) begin
            sync_out <= stage_r[2];
         end
      end
   end
endmodule

/* inc/asbw_pkg.sv */
// Package of constants and types for the bit-wide asynchronous SRAM controller.
// ****************************************************************
// ****************************************************************
package asbw_pkg;
   localparam int unsigned CLK_PERIOD_PS       = 5000;
   localparam int unsigned ADDR_W              = 22;
   // Timing figures in picoseconds, then cycle counts (min and max figures both round up).
   localparam int unsigned WRITE_PULSE_MIN_PS  = 7000;
   localparam int unsigned ADDR_TO_DATA_MAX_PS = 10000;
   localparam int unsigned DATA_SETUP_MIN_PS   = 5000;
   localparam int unsigned OUT_FLOAT_MAX_PS    = 5000;
   localparam int unsigned WRITE_OFF_LZ_MIN_PS = 3000;
   localparam int unsigned WRITE_PULSE_CYC     = (WRITE_PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned DATA_SETUP_CYC      = (DATA_SETUP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Read sample waits out the access time, one cycle of capture margin, the three synchroniser
   // stages and the registered synchroniser output, so the bit read is never a stale one.
   localparam int unsigned READ_WAIT_CYC       = (ADDR_TO_DATA_MAX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 5;
   // Turnaround after a read or write before the next cycle may start.
   localparam int unsigned TURN_CYC            = (OUT_FLOAT_MAX_PS + WRITE_OFF_LZ_MIN_PS + CLK_PERIOD_PS - 1)
                                                 / CLK_PERIOD_PS;
   localparam int unsigned CNT_W               = 4;

   typedef enum logic [2:0] {ASBW_IDLE, ASBW_RSEL, ASBW_RWAIT, ASBW_WSETUP, ASBW_WPULSE, ASBW_TURN} asbw_state_t;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic              wdata;
   } asbw_req_t;

   typedef struct packed {
      logic              select_n;
      logic              out_en_n;
      logic              wstrobe_n;
      logic [ADDR_W-1:0] addr;
      logic              din;
   } asbw_pins_t;
endpackage

/* tb/asbw_properties.sv */
// Checker of the request handshake and the SRAM pin timing.
`timescale 1ns/10ps
module asbw_properties
   import asbw_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire asbw_req_t  req,
   input wire logic       req_ready,
   input wire logic       rd_valid,
   input wire logic       rd_data,
   input wire asbw_pins_t mem_pins,
   input wire logic       mem_dout
);
   // ****
   // Properties
   // ****
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire logic sel_n = mem_pins.select_n, oe_n = mem_pins.out_en_n, st_n = mem_pins.wstrobe_n;
   wire logic rtk = req.valid && req_ready && !req.write, wtk = req.valid && req_ready && req.write;
   sequence s_rd; (!sel_n && !oe_n && st_n)[*7] ##1 (sel_n && oe_n && rd_valid); endsequence
   sequence s_wr; (!sel_n && !st_n && oe_n)[*2] ##1 (sel_n && st_n); endsequence
   a_read_walk: assert property (rtk |-> ##2 s_rd) else $error("read walk");
   a_write_walk: assert property (wtk |-> ##2 s_wr) else $error("write walk");
   a_read_busy: assert property (rtk |=> (!req_ready)[*8] ##1 (!req_ready)[*2] ##1 req_ready)
      else $error("read busy");
   a_write_busy: assert property (wtk |=> (!req_ready)[*5] ##1 req_ready) else $error("write busy");
   a_pins_held: assert property (!sel_n || $rose(sel_n) |->
      $stable(mem_pins.addr) && $stable(mem_pins.din)) else $error("pins moved");
   a_addr_taken: assert property (rtk || wtk |=> mem_pins.addr == $past(req.addr)) else $error("addr");
   a_data_taken: assert property (wtk |=> mem_pins.din == $past(req.wdata)) else $error("din");
   a_idle_quiet: assert property (req_ready |-> sel_n && oe_n && st_n) else $error("idle pins");
endmodule
bind asbw_ctrl asbw_properties chk_u (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .req_ready(req_ready),
   .rd_valid(rd_valid), .rd_data(rd_data), .mem_pins(mem_pins), .mem_dout(mem_dout));

/* tb/asbw_sram_model.sv */
// Behavioural bit-wide asynchronous SRAM on the far side of the controller.
`timescale 1ns/10ps
module asbw_sram_model
   import asbw_pkg::*;
(
   input wire asbw_pins_t pins,
   input wire logic       slow,
   output logic           dout
);
   logic      mem [bit [ADDR_W-1:0]];
   wire logic rd = !pins.select_n && !pins.out_en_n && pins.wstrobe_n;
   initial dout = 1'b0;
   always @* if (!pins.select_n && !pins.wstrobe_n) mem[pins.addr] = pins.din;
   // A floating output shows the inverted last bit, so a late sample cannot pass by luck.
   always @(rd or pins.addr)
      if (rd)
         dout <= #(slow ? 9.0 : 3.0) mem[pins.addr];
      else
         dout <= #1.0 ~dout;
endmodule

/* tb/testbench.sv */
// Self-checking bench of the controller against a behavioural SRAM.
`timescale 1ns/10ps
module testbench
   import asbw_pkg::*;
;
   // ****
   // Stimulus and checks
   // ****
   logic              clk_sys = 0, rst_b = 0, slow = 0, req_ready, rd_valid, rd_data, mem_dout;
   asbw_req_t         req = '0;
   asbw_pins_t        mem_pins;
   logic              ref_m [bit [ADDR_W-1:0]];
   logic              exp_q [$];
   logic [ADDR_W-1:0] pool [8];
   int                err_total = 0, n_compared = 0, seed = 19828, i, r;
   asbw_ctrl dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
      .rd_data(rd_data), .mem_pins(mem_pins), .mem_dout(mem_dout));
   asbw_sram_model mem_u (.pins(mem_pins), .slow(slow), .dout(mem_dout));
   always #2.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("compared=%0d errors=%0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // The request stays up while busy, so refusal is exercised on every call after the first.
   task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic d);
      @(negedge clk_sys);
      req <= '{1'b1, w, a, d};
      for (int n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (req_ready === 1'b1) break;
      end
      chk({31'h0, req_ready}, 32'h1);
      if (w)
         ref_m[a] = d;
      else
         exp_q.push_back(ref_m[a]);
      @(negedge clk_sys);
      req.valid <= 1'b0;
   endtask
   always @(posedge clk_sys)
      if (rd_valid === 1'b1)
         chk({31'h0, rd_data}, {31'h0, exp_q.pop_front()});
   initial begin
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_b = 1'b1;
      chk({28'h0, req_ready, mem_pins.select_n, mem_pins.out_en_n, mem_pins.wstrobe_n}, 32'hf);
      repeat (3) @(posedge clk_sys);
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         pool[i] = (i < 2) ? {ADDR_W{i[0]}} : r[ADDR_W-1:0];
      end
      for (i = 0; i < 64; i++) begin
         r = $random(seed);
         slow = (i >= 32);
         op((i < 8) || r[4], pool[i % 8], r[0]);
      end
      repeat (12) @(posedge clk_sys);
      chk(exp_q.size(), 32'h0);
      end_sim;
   end
   // About 64 operations of under 15 cycles each, with ample margin.
   initial begin
      #20000;
      err_total++;
      end_sim;
   end
endmodule
